// ### two_wire_event_sequencer.sv
// Purpose: interrupt and handshake sequencing of a two-wire serial interface
// Assumes: link events arrive on link_clk; processor side on clk
// Notes: events cross by toggle handshake with a held word
// Notes on behaviour
// [R1] interrupt only on byte, stop or arbitration completion, when enabled
// [R2] slave receive byte interrupts; first byte since start sets first-byte flag
// [R3] processor services data then programs reply, direction and proceed
// [R4] slave receive stop sets stop-seen flag and interrupts
// [R5] stop after a byte answered with reply 0 is not detected
// [R6] slave transmit byte interrupts and reports master acknowledge in reply bit
// [R7] processor loads next byte before setting direction and proceed
// [R8] master transmit interrupts per byte; processor programs direction, role, proceed
// [R9] clearing role bit in master transmit drives stop and returns idle
// [R10] master receive interrupts per byte; processor programs reply and proceed
// [R11] role cleared with proceed in master receive issues stop, goes idle
// [R12] arbitration loss clears role, sets contention flag, interrupts at stop
// [R13] proceed flag cleared before the first four interrupt conditions
// [R14] after master interrupt processor writes proceed once without polling
// [R15] interrupt marks stable status; registers may change during transfer
// [R16] processor writes control register to launch the next transaction
// [R17] two-wire interrupt uses lowest-priority vector at address 0x0018
// [R18] acknowledging the interrupt clears its pending flip-flop
// [R19] request pending until acknowledged, not lost while global enable off
`timescale 1ns/100ps
module two_wire_event_sequencer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic link_event_valid,
   input wire tw_seq_pkg::event_word_t link_event,
   input wire logic ctrl_write,
   input wire tw_seq_pkg::control_t ctrl_wdata,
   input wire logic irq_enable,
   input wire logic global_irq_enable,
   input wire logic irq_ack,
   output logic irq_out,
   output logic [15:0] irq_vector,
   output tw_seq_pkg::status_t status,
   output tw_seq_pkg::mode_t mode,
   output logic stop_request
);

   // link domain: capture an event word and toggle
   tw_seq_pkg::event_word_t ev_hold_reg, ev_hold_next;
   logic ev_tog_reg, ev_tog_next;
   logic arm_stop_reg, arm_stop_next;

   always_comb begin
      ev_hold_next = ev_hold_reg;
      ev_tog_next = ev_tog_reg;
      if (link_event_valid) begin
         ev_hold_next = link_event;
         ev_tog_next = ~ev_tog_reg;
      end
   end

   // held word, stable until the next event
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_hold_reg <= '0;
      end else begin
         ev_hold_reg <= ev_hold_next;
      end
   end

   // toggle announcing a new held word
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_tog_reg <= 1'b0;
      end else begin
         ev_tog_reg <= ev_tog_next;
      end
   end

   // system domain: toggle synchroniser and edge detect
   logic [1:0] tog_sync_reg, tog_sync_next;
   logic tog_seen_reg, tog_seen_next;
   tw_seq_pkg::event_word_t ev_word_reg, ev_word_next;
   logic ev_strobe;

   always_comb begin
      tog_sync_next = {tog_sync_reg[0], ev_tog_reg};
      tog_seen_next = tog_sync_reg[1];
      ev_word_next = ev_hold_reg;
   end

   // two-stage toggle synchroniser and its edge detector
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tog_sync_reg <= tw_seq_pkg::SYNC_ZERO;
         tog_seen_reg <= 1'b0;
      end else begin
         tog_sync_reg <= tog_sync_next;
         tog_seen_reg <= tog_seen_next;
      end
   end

   // held word sampled every cycle; settled before the toggle lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_word_reg <= '0;
      end else begin
         ev_word_reg <= ev_word_next;
      end
   end

   // the sampled word settles one system cycle before the toggle lands
   assign ev_strobe = tog_sync_reg[1] ^ tog_seen_reg;

   // sequencer state
   tw_seq_pkg::status_t st_reg, st_next;
   tw_seq_pkg::mode_t mode_reg, mode_next;
   logic pend_reg, pend_next;
   logic irq_reg, irq_next;
   logic stop_reg, stop_next;
   logic arb_wait_reg, arb_wait_next;
   logic raise;

   function automatic tw_seq_pkg::mode_t mode_of(input logic role, input logic dir);
      if (role)
         mode_of = dir ? tw_seq_pkg::MODE_MASTER_TX : tw_seq_pkg::MODE_MASTER_RX;
      else
         mode_of = dir ? tw_seq_pkg::MODE_SLAVE_TX : tw_seq_pkg::MODE_SLAVE_RX;
   endfunction : mode_of

   function automatic logic is_slave_rx(input tw_seq_pkg::mode_t m);
      is_slave_rx = (m == tw_seq_pkg::MODE_SLAVE_RX);
   endfunction : is_slave_rx

   // modes in which a byte event completes a transfer
   function automatic logic takes_bytes(input tw_seq_pkg::mode_t m);
      case (m)
         tw_seq_pkg::MODE_SLAVE_RX: takes_bytes = 1'b1;
         tw_seq_pkg::MODE_SLAVE_TX: takes_bytes = 1'b1;
         tw_seq_pkg::MODE_MASTER_TX: takes_bytes = 1'b1;
         tw_seq_pkg::MODE_MASTER_RX: takes_bytes = 1'b1;
         default: takes_bytes = 1'b0;
      endcase
   endfunction : takes_bytes

   always_comb begin
      st_next = st_reg;
      mode_next = mode_reg;
      arb_wait_next = arb_wait_reg;
      arm_stop_next = arm_stop_reg;
      stop_next = 1'b0;
      raise = 1'b0;
      // processor launches next transaction
      if (ctrl_write) begin
         st_next.reply_bit = ctrl_wdata.reply_bit; // [R3] [R10]
         st_next.transmit_dir_bit = ctrl_wdata.transmit_dir_bit; // [R7] [R8]
         st_next.proceed_flag = ctrl_wdata.proceed_flag; // [R16] [R14]
         st_next.controller_role_bit = ctrl_wdata.controller_role_bit;
         st_next.first_byte_flag = 1'b0;
         st_next.stop_seen_flag = 1'b0;
         st_next.contention_lost_flag = 1'b0;
         if (st_reg.controller_role_bit && !ctrl_wdata.controller_role_bit) begin
            stop_next = 1'b1; // [R9] [R11]
            mode_next = tw_seq_pkg::MODE_IDLE;
         end else if (ctrl_wdata.proceed_flag) begin
            mode_next = mode_of(ctrl_wdata.controller_role_bit, ctrl_wdata.transmit_dir_bit);
         end
         if (is_slave_rx(mode_reg))
            arm_stop_next = ctrl_wdata.reply_bit; // [R5]
      end
      // hardware events; status may change while the transfer runs
      if (ev_strobe) begin // [R15]
         case (ev_word_reg.kind)
            tw_seq_pkg::EV_BYTE: begin
               if (takes_bytes(mode_reg)) begin
                  st_next.proceed_flag = 1'b0; // [R13]
                  raise = 1'b1; // [R1]
               end
               case (mode_reg)
                  tw_seq_pkg::MODE_SLAVE_RX: begin
                     st_next.first_byte_flag = ev_word_reg.first_byte; // [R2]
                     arm_stop_next = 1'b1;
                  end
                  tw_seq_pkg::MODE_SLAVE_TX: begin
                     st_next.reply_bit = ev_word_reg.acked; // [R6]
                  end
                  tw_seq_pkg::MODE_MASTER_TX: begin
                     raise = 1'b1; // [R8]
                  end
                  tw_seq_pkg::MODE_MASTER_RX: begin
                     raise = 1'b1; // [R10]
                  end
                  default: begin
                     raise = 1'b0;
                  end
               endcase
            end
            tw_seq_pkg::EV_STOP: begin
               if (arb_wait_reg) begin
                  raise = 1'b1; // [R12]
                  arb_wait_next = 1'b0;
                  mode_next = tw_seq_pkg::MODE_IDLE;
               end else if (is_slave_rx(mode_reg) && arm_stop_reg) begin
                  st_next.stop_seen_flag = 1'b1; // [R4]
                  st_next.proceed_flag = 1'b0; // [R13]
                  raise = 1'b1;
                  mode_next = tw_seq_pkg::MODE_IDLE;
               end
            end
            tw_seq_pkg::EV_ARB_LOST: begin
               st_next.controller_role_bit = 1'b0; // [R12]
               st_next.contention_lost_flag = 1'b1;
               arb_wait_next = 1'b1;
            end
            default: begin
               raise = 1'b0;
            end
         endcase
      end
   end

   // pending request: set wins over acknowledge, held while globally disabled
   always_comb begin
      pend_next = pend_reg;
      if (irq_ack)
         pend_next = 1'b0; // [R18]
      if (raise && irq_enable)
         pend_next = 1'b1; // [R19] [R1]
   end

   // line gated by the global enable; the pending bit is kept
   always_comb begin
      irq_next = pend_next && global_irq_enable;
   end

   // pending bit and interrupt line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         pend_reg <= pend_next;
         irq_reg <= irq_next;
      end
   end

   // status flags and mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         mode_reg <= tw_seq_pkg::MODE_IDLE;
      end else begin
         st_reg <= st_next;
         mode_reg <= mode_next;
      end
   end

   // one-cycle stop request to the link
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_reg <= 1'b0;
      end else begin
         stop_reg <= stop_next;
      end
   end

   // arbitration wait and stop arming
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arb_wait_reg <= 1'b0;
         arm_stop_reg <= 1'b0;
      end else begin
         arb_wait_reg <= arb_wait_next;
         arm_stop_reg <= arm_stop_next;
      end
   end

   // fixed vector of the two-wire source
   logic [15:0] vec_reg, vec_next;

   always_comb begin
      vec_next = tw_seq_pkg::IRQ_VECTOR_ADDR; // [R17]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vec_reg <= tw_seq_pkg::IRQ_VECTOR_ADDR; // [R17]
      end else begin
         vec_reg <= vec_next;
      end
   end

   assign irq_out = irq_reg;
   assign irq_vector = vec_reg;
   assign status = st_reg;
   assign mode = mode_reg;
   assign stop_request = stop_reg;

endmodule : two_wire_event_sequencer

// ### tw_seq_pkg.sv
// Purpose: shared types and constants for the two-wire event sequencer
// Assumes: 125 MHz system clock, link logic on the two-wire bus clock domain
// Notes: status and control travel as packed structs
package tw_seq_pkg;

   localparam logic [15:0] IRQ_VECTOR_ADDR = 16'h0018;

   typedef enum logic [2:0] {
      MODE_IDLE = 3'h0,
      MODE_SLAVE_RX = 3'h1,
      MODE_SLAVE_TX = 3'h3,
      MODE_MASTER_TX = 3'h2,
      MODE_MASTER_RX = 3'h6
   } mode_t;

   // one-shot event codes reported by the link engine
   typedef enum logic [2:0] {
      EV_NONE = 3'h0,
      EV_BYTE = 3'h1,
      EV_STOP = 3'h3,
      EV_ARB_LOST = 3'h2
   } link_event_t;

   typedef struct packed {
      logic first_byte_flag;
      logic stop_seen_flag;
      logic contention_lost_flag;
      logic reply_bit;
      logic controller_role_bit;
      logic transmit_dir_bit;
      logic proceed_flag;
   } status_t;

   typedef struct packed {
      logic reply_bit;
      logic controller_role_bit;
      logic transmit_dir_bit;
      logic proceed_flag;
   } control_t;

   typedef struct packed {
      link_event_t kind;
      logic first_byte;
      logic acked;
   } event_word_t;

   localparam logic [1:0] SYNC_ZERO = 2'h0;

endpackage : tw_seq_pkg

// ### tw_seq_asserts.sv
// Purpose: port checks for the event sequencer
// Assumes: clk domain ports only
// Notes: bound to every sequencer instance
`timescale 1ns/100ps
module tw_seq_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ctrl_write,
   input wire tw_seq_pkg::control_t ctrl_wdata,
   input wire logic global_irq_enable,
   input wire logic irq_ack,
   input wire logic irq_out,
   input wire logic [15:0] irq_vector,
   input wire tw_seq_pkg::status_t status,
   input wire tw_seq_pkg::mode_t mode,
   input wire logic stop_request
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_vector_fixed: assert property (irq_vector == tw_seq_pkg::IRQ_VECTOR_ADDR)
      else $error("vector wrong");
   a_irq_gated: assert property (!global_irq_enable |=> !irq_out)
      else $error("irq while disabled");
   a_ack_clears: assert property (irq_ack |-> ##[1:3] !irq_out)
      else $error("ack kept irq");
   a_stop_pulse: assert property (stop_request |=> !stop_request)
      else $error("stop too long");
   a_stop_cause: assert property (stop_request |-> $past(ctrl_write)
      && !$past(ctrl_wdata.controller_role_bit)) else $error("stray stop");
   a_stop_idle: assert property (stop_request |-> mode == tw_seq_pkg::MODE_IDLE)
      else $error("not idle");
   a_role_write: assert property (ctrl_write |=> status.controller_role_bit
      == $past(ctrl_wdata.controller_role_bit)) else $error("role lost");
   a_proceed_clr: assert property ($rose(irq_out) && !status.contention_lost_flag
      && mode != tw_seq_pkg::MODE_MASTER_RX |-> !status.proceed_flag)
      else $error("proceed set");
   a_arb_role: assert property ($rose(status.contention_lost_flag)
      |-> !status.controller_role_bit) else $error("role kept");
endmodule : tw_seq_asserts
bind two_wire_event_sequencer tw_seq_asserts chk_u (.clk, .rst_n, .ctrl_write,
   .ctrl_wdata, .global_irq_enable, .irq_ack, .irq_out, .irq_vector, .status,
   .mode, .stop_request);

// ### tw_link_model.sv
// Purpose: far-side bus model reporting link events
// Assumes: link clock runs only within a frame
// Notes: idle event lines show the inverse word
`timescale 1ns/100ps
module tw_link_model (
   output logic link_clk,
   output logic link_event_valid,
   output tw_seq_pkg::event_word_t link_event
);
   initial begin
      link_clk = 0;
      link_event_valid = 0;
      link_event = '0;
   end
   task automatic send(input tw_seq_pkg::event_word_t w);
      #35;
      link_event = w;
      link_event_valid = 1;
      #32 link_clk = 1;
      #32 link_clk = 0;
      link_event_valid = 0;
      link_event = ~w;
      repeat (3) begin
         #32 link_clk = 1;
         #32 link_clk = 0;
      end
   endtask : send
endmodule : tw_link_model

// ### two_wire_event_sequencer_tb.sv
// Purpose: self-checking bench of the event sequencer
// Assumes: processor side driven at falling clk
// Notes: interrupts pop noted flags
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module two_wire_event_sequencer_tb;
   logic clk = 0, rst_n = 0, ctrl_write = 0, irq_ack = 0, irq_q = 0;
   logic irq_enable = 1, global_irq_enable = 1, lost = 0, r;
   logic irq_out, stop_request, link_clk, link_event_valid;
   logic [15:0] irq_vector;
   logic [1:0] exp_q[$];
   logic [1:0] e;
   tw_seq_pkg::control_t ctrl_wdata = '0;
   tw_seq_pkg::event_word_t link_event;
   tw_seq_pkg::status_t status;
   tw_seq_pkg::mode_t mode;
   int failures = 0, tests_run = 0, cyc = 0, seed = 49;
   always #4 clk = ~clk;
   tw_link_model m_u (.link_clk, .link_event_valid, .link_event);
   two_wire_event_sequencer dut_u (.clk, .rst_n, .link_clk, .link_event_valid,
      .link_event, .ctrl_write, .ctrl_wdata, .irq_enable, .global_irq_enable,
      .irq_ack, .irq_out, .irq_vector, .status, .mode, .stop_request);
   task end_of_test;
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         end_of_test;
      end
   end
   // monitor: each rising interrupt takes the oldest note
   always @(posedge clk) begin
      irq_q <= irq_out;
      if (irq_out === 1'b1 && irq_q === 1'b0) begin
         if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
         else begin
            e = exp_q.pop_front();
            `CHK({status.first_byte_flag, status.contention_lost_flag}, e)
         end
      end
   end
   // one control write, ctrl_write held for one clk cycle from a falling edge
   task wr(input logic [3:0] c);
      @(negedge clk);
      ctrl_wdata = c;
      ctrl_write = 1;
      @(negedge clk);
      ctrl_write = 0;
   endtask : wr
   task ack;
      int n;
      n = 0;
      while (irq_out !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      `CHK(irq_out, 1'b1)
      @(negedge clk);
      irq_ack = 1;
      @(negedge clk);
      irq_ack = 0;
      repeat (4) @(negedge clk);
   endtask : ack
   task quiet;
      repeat (12) @(negedge clk);
      `CHK(irq_out, 1'b0)
   endtask : quiet
   task ev(input logic [2:0] k, input logic f, input logic a, input logic x);
      if (x) exp_q.push_back({f, lost});
      m_u.send({k, f, a});
      if (x) ack;
   endtask : ev
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1;
      `CHK(irq_vector, tw_seq_pkg::IRQ_VECTOR_ADDR)
      wr(4'h9);
      ev(3'h1, 1'b1, 1'b0, 1'b1);
      wr(4'h9);
      ev(3'h1, 1'b0, 1'b0, 1'b1);
      wr(4'h9);
      ev(3'h3, 1'b0, 1'b0, 1'b1);
      `CHK(status.stop_seen_flag, 1'b1)
      wr(4'h9);
      ev(3'h1, 1'b0, 1'b0, 1'b1);
      wr(4'h1);
      `CHK(stop_request, 1'b0)
      ev(3'h3, 1'b0, 1'b0, 1'b0);
      quiet;
      wr(4'h9);
      global_irq_enable = 0;
      exp_q.push_back(2'h0);
      ev(3'h1, 1'b0, 1'b0, 1'b0);
      quiet;
      global_irq_enable = 1;
      ack;
      wr(4'h9);
      irq_enable = 0;
      ev(3'h1, 1'b0, 1'b0, 1'b0);
      quiet;
      irq_enable = 1;
      repeat (4) begin
         wr(4'h3);
         r = 1'($random(seed));
         ev(3'h1, 1'b0, r, 1'b1);
         `CHK(status.reply_bit, r)
      end
      wr(4'h7);
      ev(3'h1, 1'b0, 1'b0, 1'b1);
      wr(4'h3);
      `CHK(stop_request, 1'b1)
      `CHK(mode, tw_seq_pkg::MODE_IDLE)
      wr(4'h5);
      ev(3'h1, 1'b0, 1'b0, 1'b1);
      wr(4'h1);
      `CHK(stop_request, 1'b1)
      `CHK(mode, tw_seq_pkg::MODE_IDLE)
      wr(4'h7);
      ev(3'h2, 1'b0, 1'b0, 1'b0);
      quiet;
      `CHK({status.contention_lost_flag, status.controller_role_bit}, 2'h2)
      lost = 1;
      ev(3'h3, 1'b0, 1'b0, 1'b1);
      end_of_test;
   end
endmodule : two_wire_event_sequencer_tb
